// ==== hw/fcl_cfg.svh ====
// Flash configuration loader constants: flash map, register map and timing
`ifndef FCL_CFG_SVH
`define FCL_CFG_SVH

// ---------------------------------------------------------------
// Flash map (byte addresses)
// ---------------------------------------------------------------
`define FCL_FLASH_AW 26
`define FCL_OPT_BASE 26'h0018000
`define FCL_OPT_END 26'h001FFFF
`define FCL_FACTORY_BASE 26'h0020000
`define FCL_FACTORY_END 26'h063FFFF
`define FCL_USER1_BASE 26'h0640000
`define FCL_USER1_END 26'h0C5FFFF
`define FCL_USER2_BASE 26'h0C60000
`define FCL_USER2_END 26'h127FFFF
`define FCL_WORD_BYTES 26'h0000002

// ---------------------------------------------------------------
// Register map and fields
// ---------------------------------------------------------------
`define FCL_REG_CTRL 8'h00
`define FCL_REG_STATUS 8'h04
`define FCL_REG_OPTION 8'h08
`define FCL_CTRL_START 0
`define FCL_CTRL_TCK 1
`define FCL_CTRL_TMS 2
`define FCL_CTRL_TDI 3
`define FCL_RESP_OKAY 2'h0
`define FCL_RESP_SLVERR 2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define FCL_CLK_NS 100
`define FCL_NCFG_LOW_NS 2000
`define FCL_NCFG_LOW_CYC ((`FCL_NCFG_LOW_NS + `FCL_CLK_NS - 1) / `FCL_CLK_NS)
`define FCL_STATUS_WAIT_NS 100000
`define FCL_STATUS_WAIT_CYC (`FCL_STATUS_WAIT_NS / `FCL_CLK_NS)
`define FCL_DONE_WAIT_NS 10000
`define FCL_DONE_WAIT_CYC (`FCL_DONE_WAIT_NS / `FCL_CLK_NS)

`endif

// ==== hw/fcl_loader.sv ====
// Flash to serial configuration loader with page select, status LEDs and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "fcl_cfg.svh"

module fcl_loader
	import fcl_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int WORD_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Switches, jumpers and buttons (the _n inputs active low)
	input wire logic power_up_page_select,
	input wire logic reconfigure_button_n,
	input wire logic page_cycle_button_n,
	input wire logic jtag_takeover_jumper_n,
	input wire logic controller_chain_include_n,
	input wire logic jtag_lock_switch,
	input wire logic clock_select_switch,
	input wire logic tamper_demo_switch,
	// Flash read port
	output logic [`FCL_FLASH_AW-1:0] flash_addr,
	output logic flash_read,
	input wire logic [WORD_W-1:0] flash_rdata,
	input wire logic flash_rvalid,
	// Target passive serial configuration
	output logic target_nconfig_n,
	output logic target_dclk,
	output logic target_data0,
	input wire logic target_nstatus_n,
	input wire logic target_conf_done,
	// Target JTAG takeover
	output logic target_jtag_tck,
	output logic target_jtag_tms,
	output logic target_jtag_tdi,
	output logic target_jtag_oe,
	// Indicators and board controls
	output logic page_select_led_factory_n,
	output logic page_select_led_user1_n,
	output logic page_select_led_user2_n,
	output logic loading_led,
	output logic error_led,
	output logic config_done_indicator,
	output logic factory_led,
	output logic takeover_led,
	output logic controller_chain_bypass,
	output logic target_jtag_lock,
	output logic clock_from_oscillator,
	output logic tamper_demo_enable
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	fcl_state_t state_reg;
	fcl_page_t sel_page_reg;
	fcl_page_t load_page_reg;
	logic pu_pending_reg;
	logic reconf_prev_reg;
	logic cycle_prev_reg;
	logic soft_start_reg;
	logic [11:0] cnt_reg;
	logic [WORD_W-1:0] word_reg;
	logic word_load_reg;
	logic [WORD_W-1:0] option_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [2:0] jtag_gpio_reg;
	logic ser_busy;
	logic ser_done;
	logic reconf_release;
	logic cycle_release;
	logic start_go;
	logic do_write;
	fcl_page_t start_page;
	logic [2:0] leds_n;

	assign reconf_release = reconfigure_button_n && !reconf_prev_reg;
	assign cycle_release = page_cycle_button_n && !cycle_prev_reg;
	// A start is honoured only between attempts
	assign start_go = (state_reg == ST_IDLE) && (pu_pending_reg || reconf_release || soft_start_reg);
	// Power-up uses the switch, later starts use the selection shown on the LEDs
	assign start_page = pu_pending_reg ? (power_up_page_select ? PG_USER1 : PG_FACTORY) : sel_page_reg;
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign leds_n = fcl_page_leds_n(sel_page_reg);

	// ---------------------------------------------------------------
	// Buttons and page selection
	// ---------------------------------------------------------------

	// Button history for release detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reconf_prev_reg <= 1'b1;
			cycle_prev_reg <= 1'b1;
		end else begin
			reconf_prev_reg <= reconfigure_button_n;
			cycle_prev_reg <= page_cycle_button_n;
		end
	end

	// Selection follows power-up page, then advances on page-cycle release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_page_reg <= PG_FACTORY;
		end else if (pu_pending_reg) begin
			sel_page_reg <= start_page;
		end else if (cycle_release) begin
			unique case (sel_page_reg)
				PG_FACTORY: sel_page_reg <= PG_USER1;
				PG_USER1: sel_page_reg <= PG_USER2;
				default: sel_page_reg <= PG_FACTORY;
			endcase
		end
	end

	// Page LEDs show the current selection, lit low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_select_led_factory_n <= 1'b1;
			page_select_led_user1_n <= 1'b1;
			page_select_led_user2_n <= 1'b1;
		end else begin
			page_select_led_factory_n <= leds_n[0];
			page_select_led_user1_n <= leds_n[1];
			page_select_led_user2_n <= leds_n[2];
		end
	end

	// ---------------------------------------------------------------
	// Load sequencer
	// ---------------------------------------------------------------

	// Option read, nCONFIG pulse, status wait, word fetch and shift, completion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			pu_pending_reg <= 1'b1;
			load_page_reg <= PG_FACTORY;
			flash_addr <= '0;
			flash_read <= 1'b0;
			target_nconfig_n <= 1'b1;
			cnt_reg <= '0;
			word_reg <= '0;
			word_load_reg <= 1'b0;
			option_reg <= '0;
			loading_led <= 1'b0;
			error_led <= 1'b0;
			config_done_indicator <= 1'b0;
			factory_led <= 1'b0;
		end else begin
			word_load_reg <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (start_go) begin
						pu_pending_reg <= 1'b0;
						load_page_reg <= start_page;
						flash_addr <= `FCL_OPT_BASE;
						flash_read <= 1'b1;
						loading_led <= 1'b1;
						error_led <= 1'b0;
						config_done_indicator <= 1'b0;
						factory_led <= 1'b0;
						state_reg <= ST_OPT;
					end
				end
				ST_OPT: begin
					if (flash_rvalid) begin
						option_reg <= flash_rdata;
						flash_read <= 1'b0;
						target_nconfig_n <= 1'b0;
						cnt_reg <= '0;
						state_reg <= ST_PULSE;
					end
				end
				ST_PULSE: begin
					if (cnt_reg == 12'(`FCL_NCFG_LOW_CYC - 1)) begin
						target_nconfig_n <= 1'b1;
						cnt_reg <= '0;
						state_reg <= ST_STATUS;
					end else begin
						cnt_reg <= cnt_reg + 12'h001;
					end
				end
				ST_STATUS: begin
					if (target_nstatus_n) begin
						flash_addr <= fcl_page_base(load_page_reg);
						flash_read <= 1'b1;
						state_reg <= ST_FETCH;
					end else if (cnt_reg == 12'(`FCL_STATUS_WAIT_CYC - 1)) begin
						error_led <= 1'b1;
						loading_led <= 1'b0;
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 12'h001;
					end
				end
				ST_FETCH: begin
					if (flash_rvalid) begin
						word_reg <= flash_rdata;
						word_load_reg <= 1'b1;
						flash_read <= 1'b0;
						state_reg <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (!target_nstatus_n) begin
						error_led <= 1'b1;
						loading_led <= 1'b0;
						state_reg <= ST_IDLE;
					end else if (ser_done) begin
						if (target_conf_done) begin
							config_done_indicator <= 1'b1;
							factory_led <= (load_page_reg == PG_FACTORY);
							loading_led <= 1'b0;
							state_reg <= ST_IDLE;
						end else if (flash_addr == fcl_page_end(load_page_reg) - (`FCL_WORD_BYTES - 26'h0000001)) begin
							cnt_reg <= '0;
							state_reg <= ST_FINISH;
						end else begin
							flash_addr <= flash_addr + `FCL_WORD_BYTES;
							flash_read <= 1'b1;
							state_reg <= ST_FETCH;
						end
					end
				end
				ST_FINISH: begin
					if (target_conf_done) begin
						config_done_indicator <= 1'b1;
						factory_led <= (load_page_reg == PG_FACTORY);
						loading_led <= 1'b0;
						state_reg <= ST_IDLE;
					end else if (!target_nstatus_n || cnt_reg == 12'(`FCL_DONE_WAIT_CYC - 1)) begin
						error_led <= 1'b1;
						loading_led <= 1'b0;
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 12'h001;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Serial shifter for the fetched word
	fcl_serializer #(
		.WORD_W(WORD_W)
	) u_ser (
		.aclk(aclk),
		.aresetn(aresetn),
		.word_data(word_reg),
		.word_load(word_load_reg),
		.busy(ser_busy),
		.done(ser_done),
		.dclk(target_dclk),
		.data(target_data0)
	);

	// ---------------------------------------------------------------
	// JTAG takeover and board switches
	// ---------------------------------------------------------------

	// Takeover hands controller pins to target JTAG; controller_chain_bypass still follows its own switch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			target_jtag_oe <= 1'b0;
			takeover_led <= 1'b0;
			target_jtag_tck <= 1'b0;
			target_jtag_tms <= 1'b0;
			target_jtag_tdi <= 1'b0;
		end else begin
			target_jtag_oe <= !jtag_takeover_jumper_n;
			takeover_led <= !jtag_takeover_jumper_n;
			target_jtag_tck <= jtag_gpio_reg[0];
			target_jtag_tms <= jtag_gpio_reg[1];
			target_jtag_tdi <= jtag_gpio_reg[2];
		end
	end

	// Switch-driven board controls, OFF reads as 1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			controller_chain_bypass <= 1'b0;
			target_jtag_lock <= 1'b0;
			clock_from_oscillator <= 1'b0;
			tamper_demo_enable <= 1'b0;
		end else begin
			controller_chain_bypass <= controller_chain_include_n;
			target_jtag_lock <= jtag_lock_switch;
			clock_from_oscillator <= !clock_select_switch;
			tamper_demo_enable <= tamper_demo_switch;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite register slave
	// ---------------------------------------------------------------

	// Write address and data accepted in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FCL_RESP_OKAY;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			jtag_gpio_reg <= 3'h0;
			soft_start_reg <= 1'b0;
		end else begin
			soft_start_reg <= 1'b0;
			if (s_axi_awready && s_axi_awvalid) begin
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `FCL_RESP_OKAY;
				if (aw_addr_reg == ADDR_W'(`FCL_REG_CTRL)) begin
					if (w_strb_reg[0]) begin
						soft_start_reg <= w_data_reg[`FCL_CTRL_START];
						jtag_gpio_reg <= w_data_reg[`FCL_CTRL_TDI:`FCL_CTRL_TCK];
					end
				end else if (aw_addr_reg != ADDR_W'(`FCL_REG_STATUS) && aw_addr_reg != ADDR_W'(`FCL_REG_OPTION)) begin
					s_axi_bresp <= `FCL_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read returns control, live status or the option word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `FCL_RESP_OKAY;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `FCL_RESP_OKAY;
			if (s_axi_araddr == ADDR_W'(`FCL_REG_CTRL)) begin
				s_axi_rdata <= {28'h0000000, jtag_gpio_reg, 1'b0};
			end else if (s_axi_araddr == ADDR_W'(`FCL_REG_STATUS)) begin
				s_axi_rdata <= {23'h000000, takeover_led, load_page_reg, sel_page_reg,
					factory_led, config_done_indicator, error_led, loading_led};
			end else if (s_axi_araddr == ADDR_W'(`FCL_REG_OPTION)) begin
				s_axi_rdata <= {16'h0000, option_reg};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `FCL_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_power_page;
		start_go && pu_pending_reg |=> load_page_reg == (power_up_page_select ? PG_USER1 : PG_FACTORY);
	endproperty
	a_power_page: assert property (p_power_page) else $error("power-up page wrong");

	property p_opt_first;
		$rose(loading_led) |-> flash_read && flash_addr == `FCL_OPT_BASE;
	endproperty
	a_opt_first: assert property (p_opt_first) else $error("option word not read first");

	property p_image_range;
		state_reg == ST_FETCH |-> flash_addr >= fcl_page_base(load_page_reg) && flash_addr < fcl_page_end(load_page_reg);
	endproperty
	a_image_range: assert property (p_image_range) else $error("image address outside page");

	property p_release_sample;
		start_go && !pu_pending_reg && reconf_release |=> loading_led && load_page_reg == $past(sel_page_reg);
	endproperty
	a_release_sample: assert property (p_release_sample) else $error("reconfigure page not sampled");

	property p_led_onehot;
		aresetn |=> $onehot({!page_select_led_factory_n, !page_select_led_user1_n, !page_select_led_user2_n});
	endproperty
	a_led_onehot: assert property (p_led_onehot) else $error("page LEDs not one-hot low");

	property p_cycle_step;
		cycle_release && !pu_pending_reg |=> sel_page_reg != $past(sel_page_reg);
	endproperty
	a_cycle_step: assert property (p_cycle_step) else $error("page cycle did not advance");

	property p_load_ends;
		$fell(loading_led) |-> config_done_indicator != error_led;
	endproperty
	a_load_ends: assert property (p_load_ends) else $error("load ended without outcome");

	property p_err_clear;
		$rose(loading_led) |-> !error_led && !config_done_indicator;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error not cleared at start");

	property p_done_cause;
		$rose(config_done_indicator) |-> $past(target_conf_done) && factory_led == (load_page_reg == PG_FACTORY);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done or factory LED wrong");

	property p_takeover;
		aresetn && !jtag_takeover_jumper_n ##1 !jtag_takeover_jumper_n |-> target_jtag_oe && takeover_led;
	endproperty
	a_takeover: assert property (p_takeover) else $error("takeover not applied");

	property p_word_shift;
		word_load_reg |=> ser_busy ##1 target_dclk;
	endproperty
	a_word_shift: assert property (p_word_shift) else $error("word not shifted");

	c_done: cover property ($rose(config_done_indicator));
	c_error: cover property ($rose(error_led));
	c_reconf: cover property (start_go && reconf_release);
	c_write: cover property (s_axi_bvalid && s_axi_bready);

endmodule : fcl_loader

`default_nettype wire

// ==== hw/fcl_pkg.sv ====
// Flash configuration loader types and page decoding
`include "fcl_cfg.svh"

package fcl_pkg;

	typedef enum logic [2:0] {ST_IDLE, ST_OPT, ST_PULSE, ST_STATUS, ST_FETCH, ST_SEND, ST_FINISH} fcl_state_t;

	typedef enum logic [1:0] {PG_FACTORY, PG_USER1, PG_USER2} fcl_page_t;

	// First byte address of a hardware page
	function automatic logic [`FCL_FLASH_AW-1:0] fcl_page_base(input fcl_page_t pg);
		unique case (pg)
			PG_FACTORY: fcl_page_base = `FCL_FACTORY_BASE;
			PG_USER1: fcl_page_base = `FCL_USER1_BASE;
			default: fcl_page_base = `FCL_USER2_BASE;
		endcase
	endfunction : fcl_page_base

	// Last byte address of a hardware page
	function automatic logic [`FCL_FLASH_AW-1:0] fcl_page_end(input fcl_page_t pg);
		unique case (pg)
			PG_FACTORY: fcl_page_end = `FCL_FACTORY_END;
			PG_USER1: fcl_page_end = `FCL_USER1_END;
			default: fcl_page_end = `FCL_USER2_END;
		endcase
	endfunction : fcl_page_end

	// Active-low one-hot LED pattern of a page
	function automatic logic [2:0] fcl_page_leds_n(input fcl_page_t pg);
		unique case (pg)
			PG_FACTORY: fcl_page_leds_n = 3'h6;
			PG_USER1: fcl_page_leds_n = 3'h5;
			default: fcl_page_leds_n = 3'h3;
		endcase
	endfunction : fcl_page_leds_n

endpackage : fcl_pkg

// ==== hw/fcl_serializer.sv ====
// Word to passive-serial bit stream shifter
`timescale 1ns/1ps
`default_nettype none

module fcl_serializer #(
	parameter int WORD_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WORD_W-1:0] word_data,
	input wire logic word_load,
	output logic busy,
	output logic done,
	output logic dclk,
	output logic data
);

	localparam int CW = $clog2(WORD_W);

	logic [WORD_W-1:0] shift_reg;
	logic [CW-1:0] bit_cnt_reg;
	logic phase_reg;

	// Data is set with clock low, target samples on the rising dclk edge, LSB first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_reg <= '0;
			bit_cnt_reg <= '0;
			phase_reg <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			dclk <= 1'b0;
			data <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (word_load) begin
					shift_reg <= word_data;
					data <= word_data[0];
					bit_cnt_reg <= '0;
					phase_reg <= 1'b0;
					busy <= 1'b1;
				end
			end else if (!phase_reg) begin
				dclk <= 1'b1;
				phase_reg <= 1'b1;
			end else begin
				dclk <= 1'b0;
				phase_reg <= 1'b0;
				if (bit_cnt_reg == CW'(WORD_W - 1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					shift_reg <= shift_reg >> 1;
					data <= shift_reg[1];
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
				end
			end
		end
	end

endmodule : fcl_serializer

`default_nettype wire

// ==== verif/fcl_loader_bench.sv ====
// Self-checking bench for the flash configuration loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(34'(g), 34'(e))

module fcl_loader_bench;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, power_up_page_select;
	logic reconfigure_button_n, page_cycle_button_n, jtag_takeover_jumper_n, controller_chain_include_n;
	logic jtag_lock_switch, clock_select_switch, tamper_demo_switch, fail_req, finish_req, fr_q;
	logic [7:0] s_axi_awaddr, s_axi_araddr, r;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, flash_read, flash_rvalid;
	logic [25:0] flash_addr;
	logic [15:0] flash_rdata;
	logic target_nconfig_n, target_dclk, target_data0, target_nstatus_n, target_conf_done;
	logic target_jtag_tck, target_jtag_tms, target_jtag_tdi, target_jtag_oe, page_select_led_factory_n;
	logic page_select_led_user1_n, page_select_led_user2_n, loading_led, error_led, config_done_indicator;
	logic factory_led, takeover_led, controller_chain_bypass, target_jtag_lock, clock_from_oscillator, tamper_demo_enable;
	logic [25:0] addr_q[$];
	logic [33:0] rd_q[$];
	logic dclk_q;
	logic [15:0] sh_q;
	int errors = 0;
	int compares = 0;
	logic [2:0] leds_t[3] = '{3'h3, 3'h6, 3'h5};
	logic [25:0] base_t[3] = '{26'h0C60000, 26'h0020000, 26'h0640000};

	fcl_loader dut_u (.*);
	fcl_target_model model_u (.*);

	always #50 aclk = ~aclk;

	task automatic check(input logic [33:0] g, input logic [33:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask : check

	task automatic stop_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, resp);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge aclk);
		rd_q.push_back(e);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// Wait one load through and check the indicators it leaves
	task automatic wait_load(input logic fac, input logic [15:0] w);
		while (!loading_led) @(posedge aclk);
		`CHK(error_led, 1'b0);
		while (loading_led) @(posedge aclk);
		`CHK({error_led, factory_led}, {fail_req, fac});
		if (!fail_req) begin
			`CHK(config_done_indicator, 1'b1);
			`CHK(sh_q, w);
		end
		finish_req <= 1'b0;
	endtask : wait_load

	// Monitor: flash addresses, serial bits and read answers against the oldest note
	always @(posedge aclk) begin
		fr_q <= flash_read;
		dclk_q <= target_dclk;
		if (target_dclk && !dclk_q) sh_q <= {target_data0, sh_q[15:1]};
		if (flash_read && !fr_q && addr_q.size() != 0) `CHK(flash_addr, addr_q.pop_front());
		if (s_axi_rvalid && s_axi_rready && rd_q.size() != 0) `CHK({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
	end

	// Watchdog
	initial begin
		repeat (30000) @(posedge aclk);
		errors++;
		stop_test();
	end

	// Main sequence
	initial begin
		void'($urandom(99356));
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fail_req, finish_req, aresetn} <= '0;
		{reconfigure_button_n, page_cycle_button_n, jtag_takeover_jumper_n, power_up_page_select} <= '1;
		{controller_chain_include_n, jtag_lock_switch, clock_select_switch, tamper_demo_switch, fr_q} <= '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		s_axi_wstrb <= 4'hF;
		addr_q = '{26'h0018000, 26'h0640000};
		tick(3);
		aresetn <= 1'b1;
		tick(3);
		`CHK({page_select_led_user2_n, page_select_led_user1_n, page_select_led_factory_n}, 3'h5);
		finish_req <= 1'b1;
		wait_load(1'b0, 16'h6400);
		fail_req <= 1'b1;
		addr_q.push_back(26'h0018000);
		reconfigure_button_n <= 1'b0;
		tick(3);
		reconfigure_button_n <= 1'b1;
		wait_load(1'b0, 16'h6400);
		fail_req <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			addr_q.push_back(26'h0018000);
			addr_q.push_back(base_t[i]);
			reconfigure_button_n <= 1'b0;
			tick(3);
			page_cycle_button_n <= 1'b0;
			tick(3);
			page_cycle_button_n <= 1'b1;
			tick(3);
			`CHK({page_select_led_user2_n, page_select_led_user1_n, page_select_led_factory_n}, leds_t[i]);
			reconfigure_button_n <= 1'b1;
			finish_req <= 1'b1;
			wait_load(i == 1, base_t[i][23:8]);
		end
		axi_rd(8'h04, {2'h0, 32'h00000054});
		axi_rd(8'h08, {2'h0, 32'h00000180});
		axi_rd(8'h0C, {2'h2, 32'h0});
		axi_wr(8'h10, 32'h0, 2'h2);
		for (int i = 0; i < 6; i++) begin
			r = 8'($urandom);
			{jtag_takeover_jumper_n, controller_chain_include_n, jtag_lock_switch, clock_select_switch, tamper_demo_switch} <= r[4:0];
			axi_wr(8'h00, {28'h0, r[7:5], 1'b0}, 2'h0);
			tick(2);
			`CHK({takeover_led, target_jtag_oe, controller_chain_bypass, target_jtag_lock}, {!r[4], !r[4], r[3], r[2]});
			`CHK({clock_from_oscillator, tamper_demo_enable}, {!r[1], r[0]});
			`CHK({target_jtag_tdi, target_jtag_tms, target_jtag_tck}, r[7:5]);
		end
		axi_rd(8'h00, {2'h0, 28'h0, r[7:5], 1'b0});
		aresetn <= 1'b0;
		power_up_page_select <= 1'b0;
		addr_q = '{26'h0018000, 26'h0020000};
		tick(3);
		aresetn <= 1'b1;
		finish_req <= 1'b1;
		wait_load(1'b1, 16'h0200);
		// Software start reloads the selected factory page
		addr_q = '{26'h0018000, 26'h0020000};
		axi_wr(8'h00, 32'h00000001, 2'h0);
		finish_req <= 1'b1;
		wait_load(1'b1, 16'h0200);
		stop_test();
	end
endmodule : fcl_loader_bench

`default_nettype wire

// ==== verif/fcl_target_model.sv ====
// Flash memory and target configuration pin model
`timescale 1ns/1ps
`default_nettype none

module fcl_target_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic flash_read,
	input wire logic [25:0] flash_addr,
	output logic [15:0] flash_rdata,
	output logic flash_rvalid,
	input wire logic target_nconfig_n,
	output logic target_nstatus_n,
	output logic target_conf_done,
	input wire logic fail_req,
	input wire logic finish_req
);
	logic [1:0] wait_reg;
	logic [15:0] junk_reg;

	// Flash answers after a random delay; the bus shows garbage outside valid
	always_ff @(posedge aclk) begin
		junk_reg <= junk_reg + 16'h1;
		flash_rvalid <= 1'b0;
		if (!aresetn) begin
			wait_reg <= 2'h0;
			junk_reg <= 16'hA5C3;
		end else if (flash_read && !flash_rvalid) begin
			flash_rvalid <= wait_reg == 2'h0;
			wait_reg <= (wait_reg == 2'h0) ? 2'($urandom) : wait_reg - 2'h1;
		end
	end
	assign flash_rdata = flash_rvalid ? flash_addr[23:8] : ~junk_reg;

	// Target holds status low while config is low; done once told to finish
	always_ff @(posedge aclk) begin
		target_nstatus_n <= target_nconfig_n && !fail_req;
		target_conf_done <= aresetn && target_nconfig_n && (target_conf_done || finish_req);
	end
endmodule : fcl_target_model

`default_nettype wire
